// ### core/uoeb_pkg.sv
// Purpose: shared constants and types for the out endpoint buffer status block
// Assumes: 8-bit registers on a plain strobe port, one 125 MHz clock
// Notes:
// Behaviour
// [RQ1] software writes an 8-bit y base byte holding address bits 10 to 3
// [RQ2] y buffer start is an 11-bit address, programmed byte on top
// [RQ3] low three bits of y base address are always zero
// [RQ4] successful out transaction into x buffer sets valid bit 7
// [RQ5] non-iso endpoint answers nak while x valid bit is set
// [RQ6] software writes 0 to valid before next non-iso packet is taken
// [RQ7] iso endpoint never naks and ignores the valid bit
// [RQ8] software should clear valid before reading an iso packet
// [RQ9] each new x packet updates count bits 6 to 0
// [RQ10] non-iso count is the packet byte count
// [RQ11] iso count is the packet sample count
// [RQ12] bytes to samples uses bytes-per-sample from configuration
// [RQ13] software reads the count to learn packet size
// [RQ14] software programs common x/y buffer size in 8-byte units; no buffer size register is implemented here
package uoeb_pkg;
   localparam int          ADDR_W        = 3;
   localparam int          MEM_ADDR_W    = 11;
   localparam int          BASE_LSB      = 3;
   localparam int          CNT_W         = 7;
   localparam int          VALID_BIT     = 7;
   localparam int          BPS_W         = 3;
   // register offsets
   localparam logic [2:0]  OFS_YBASE     = 3'h0;
   localparam logic [2:0]  OFS_XCNT      = 3'h1;
   localparam logic [2:0]  OFS_CFG       = 3'h2;
   localparam logic [2:0]  OFS_IRQ_STAT  = 3'h3;
   localparam logic [2:0]  OFS_IRQ_MASK  = 3'h4;
   // reset values
   localparam logic [7:0]  RST_YBASE     = 8'h00;
   localparam logic [7:0]  RST_XCNT      = 8'h00;
   localparam logic [7:0]  RST_CFG       = 8'h00;
   localparam logic [7:0]  RST_MASK      = 8'h00;
   // configuration fields
   localparam int          CFG_ISO_BIT   = 7;
   localparam int          CFG_BPS_LSB   = 0;
   // interrupt status bits
   localparam int          IRQ_PKT_BIT   = 0;
   localparam int          IRQ_NAK_BIT   = 1;
   localparam int          IRQ_W         = 2;

   typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK} uoeb_hs_e;

   typedef struct packed {
      logic                done;   // successful transaction ended
      logic [CNT_W-1:0]    bytes;  // bytes received
   } uoeb_pkt_s;

   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          wdata;
      logic                wr;
      logic                rd;
   } uoeb_bus_s;
endpackage

// ### core/uoeb_sample_div.sv
// Purpose: converts a received byte count to a sample count
// Assumes: bytes-per-sample code 0 means one byte per sample
// Notes: combinational divide by 1..8, small widths keep it cheap
`timescale 1ns/1ns
`default_nettype none
module uoeb_sample_div
   import uoeb_pkg::*;
(
   input  wire logic [CNT_W-1:0] i_bytes,   // packet length in bytes
   input  wire logic [BPS_W-1:0] i_bps,     // bytes per sample minus one
   output logic      [CNT_W-1:0] o_samples  // packet length in samples
);
   wire logic [3:0] divisor = {1'b0, i_bps} + 4'h1; // [RQ12]
   assign o_samples = i_bytes / CNT_W'(divisor);
endmodule
`default_nettype wire

// ### core/uoeb_irq.sv
// Purpose: sticky status with mask and level interrupt
// Assumes: write one to clear; a set in the same cycle wins
// Notes: none
`timescale 1ns/1ns
`default_nettype none
module uoeb_irq
   import uoeb_pkg::*;
(
   input  wire logic              i_clk,     // system clock
   input  wire logic              i_nrst,    // async reset, low
   input  wire logic [IRQ_W-1:0]  i_set,     // event pulses
   input  wire logic [IRQ_W-1:0]  i_clr,     // write-one-to-clear bits
   input  wire logic              i_mask_wr, // mask write
   input  wire logic [IRQ_W-1:0]  i_mask_d,  // mask write data
   output logic      [IRQ_W-1:0]  o_stat,    // sticky status
   output logic      [IRQ_W-1:0]  o_mask,    // mask
   output logic                   o_irq      // level interrupt
);
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   wire  logic [IRQ_W-1:0] stat_d = (stat_q & ~i_clr) | i_set;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stat_q <= '0;
         mask_q <= RST_MASK[IRQ_W-1:0];
      end else begin
         stat_q <= stat_d;
         if (i_mask_wr) begin
            mask_q <= i_mask_d;
         end
      end
   end
   assign o_stat = stat_q;
   assign o_mask = mask_q;
   assign o_irq  = |(stat_q & mask_q);
endmodule
`default_nettype wire

// ### core/uoeb_top.sv
// Purpose: out endpoint y base address and x count/status registers
// Assumes: buffer manager pulses packet done with byte count after CRC ok
// Notes: handshake decision is combinational so it is ready on token arrival
`timescale 1ns/1ns
`default_nettype none
module uoeb_top
   import uoeb_pkg::*;
(
   input  wire logic                  I_CLK_SYS,      // 125 MHz clock
   input  wire logic                  I_NRST,         // async reset, low
   input  wire logic [ADDR_W-1:0]     I_ADDR,         // register address
   input  wire logic [7:0]            I_WDATA,        // write data
   input  wire logic                  I_WR,           // write strobe
   input  wire logic                  I_RD,           // read strobe
   output logic      [7:0]            O_RDATA,        // read data, cycle after strobe
   input  wire logic                  I_OUT_TOKEN,    // out/setup token for this endpoint
   input  wire logic                  I_PKT_DONE,     // successful transaction ended
   input  wire logic [CNT_W-1:0]      I_PKT_BYTES,    // bytes in that packet
   output logic      [1:0]            O_HANDSHAKE,    // handshake to send
   output logic                       O_ACCEPT,       // data may go to x buffer
   output logic      [MEM_ADDR_W-1:0] O_Y_BASE_ADDR,  // y buffer start address
   output logic                       O_IRQ           // interrupt, high level
);
   uoeb_bus_s bus;
   assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

   logic [7:0]       ybase_q;
   logic [7:0]       xcnt_q;
   logic [7:0]       cfg_q;
   logic [7:0]       rdata_q;
   logic [CNT_W-1:0] samples;
   logic [IRQ_W-1:0] stat;
   logic [IRQ_W-1:0] mask;

   // address decode
   wire logic wr_ybase = bus.wr && (bus.addr == OFS_YBASE);
   wire logic wr_xcnt  = bus.wr && (bus.addr == OFS_XCNT);
   wire logic wr_cfg   = bus.wr && (bus.addr == OFS_CFG);
   wire logic wr_stat  = bus.wr && (bus.addr == OFS_IRQ_STAT);
   wire logic wr_mask  = bus.wr && (bus.addr == OFS_IRQ_MASK);

   wire logic is_iso   = cfg_q[CFG_ISO_BIT];
   wire logic valid    = xcnt_q[VALID_BIT];
   // iso never naks; valid bit is ignored for it
   wire logic nak      = I_OUT_TOKEN && !is_iso && valid; // [RQ5] [RQ7] [RQ6]
   wire logic take     = I_PKT_DONE && (is_iso || !valid); // [RQ7]

   uoeb_sample_div u_div (
      .i_bytes   (I_PKT_BYTES),
      .i_bps     (cfg_q[CFG_BPS_LSB +: BPS_W]),
      .o_samples (samples)
   );

   wire logic [CNT_W-1:0] new_cnt = is_iso ? samples : I_PKT_BYTES; // [RQ10] [RQ11]

   // a packet landing in the same cycle as a software write wins
   wire logic [7:0] xcnt_d = take    ? {1'b1, new_cnt} : // [RQ4] [RQ9]
                             wr_xcnt ? bus.wdata : xcnt_q;

   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         ybase_q <= RST_YBASE;
         xcnt_q  <= RST_XCNT;
         cfg_q   <= RST_CFG;
      end else begin
         xcnt_q <= xcnt_d;
         if (wr_ybase) begin
            ybase_q <= bus.wdata; // [RQ1]
         end
         if (wr_cfg) begin
            cfg_q <= bus.wdata;
         end
      end
   end

   uoeb_irq u_irq (
      .i_clk     (I_CLK_SYS),
      .i_nrst    (I_NRST),
      .i_set     ({nak, take}),
      .i_clr     (wr_stat ? bus.wdata[IRQ_W-1:0] : '0),
      .i_mask_wr (wr_mask),
      .i_mask_d  (bus.wdata[IRQ_W-1:0]),
      .o_stat    (stat),
      .o_mask    (mask),
      .o_irq     (O_IRQ)
   );

   // unmapped addresses read zero
   wire logic [7:0] rd_mux =
      (bus.addr == OFS_YBASE)    ? ybase_q :
      (bus.addr == OFS_XCNT)     ? xcnt_q  : // [RQ13]
      (bus.addr == OFS_CFG)      ? cfg_q   :
      (bus.addr == OFS_IRQ_STAT) ? {6'h00, stat} :
      (bus.addr == OFS_IRQ_MASK) ? {6'h00, mask} : 8'h00;

   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= bus.rd ? rd_mux : 8'h00;
      end
   end

   assign O_RDATA       = rdata_q;
   assign O_Y_BASE_ADDR = {ybase_q, {BASE_LSB{1'b0}}}; // [RQ2] [RQ3]
   assign O_ACCEPT      = I_OUT_TOKEN && !nak;
   assign O_HANDSHAKE   = !I_OUT_TOKEN ? HS_NONE :
                          nak ? HS_NAK : (is_iso ? HS_NONE : HS_ACK);
endmodule
`default_nettype wire

// ### dv/uoeb_chk.sv
// Purpose: port assertions for uoeb_top
// Assumes: the host keeps its token up through the done cycle
// Notes: the valid bit is no port, so nak is checked just after a taken packet
`timescale 1ns/1ns
`default_nettype none
module uoeb_chk
   import uoeb_pkg::*;
(
   input wire logic                  I_CLK_SYS, I_NRST, I_WR, I_RD, I_OUT_TOKEN, // bus and token
   input wire logic                  I_PKT_DONE, O_ACCEPT, O_IRQ,                // packet and irq
   input wire logic [ADDR_W-1:0]     I_ADDR,                                     // register address
   input wire logic [7:0]            I_WDATA, O_RDATA,                           // bus data
   input wire logic [1:0]            O_HANDSHAKE,                                // handshake
   input wire logic [MEM_ADDR_W-1:0] O_Y_BASE_ADDR                               // y start
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);
   a_ybase_low_zero: assert property (O_Y_BASE_ADDR[2:0] == 3'h0) else $error("y low bits set");
   a_ybase_loads:
      assert property (I_WR && I_ADDR == OFS_YBASE |=> O_Y_BASE_ADDR[10:3] == $past(I_WDATA)) else $error("y base");
   a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00) else $error("stray read data");
   a_nak_refuses: assert property (O_HANDSHAKE == HS_NAK |-> I_OUT_TOKEN && !O_ACCEPT) else $error("nak");
   a_ack_accepts: assert property (O_HANDSHAKE == HS_ACK |-> O_ACCEPT) else $error("ack not taken");
   a_iso_no_nak: assert property (I_OUT_TOKEN && O_HANDSHAKE == HS_NONE |-> O_ACCEPT) else $error("iso");
   a_token_idle: assert property (!I_OUT_TOKEN |-> O_HANDSHAKE == HS_NONE && !O_ACCEPT) else $error("idle");
   a_nak_after_pkt:
      assert property (I_PKT_DONE && O_HANDSHAKE == HS_ACK |=> !I_OUT_TOKEN || O_HANDSHAKE == HS_NAK) else $error("no nak");
   // only a register write can clear valid or switch to iso, so a nak persists without one
   a_nak_holds:
      assert property (O_HANDSHAKE == HS_NAK && !I_WR ##1 I_OUT_TOKEN |-> O_HANDSHAKE == HS_NAK) else $error("nak dropped");
   a_mask_all_off:
      assert property (I_WR && I_ADDR == OFS_IRQ_MASK && I_WDATA == 8'h00 |=> !O_IRQ) else $error("irq masked");
   c_nak: cover property (O_HANDSHAKE == HS_NAK);
   c_iso_pkt: cover property (I_PKT_DONE && O_HANDSHAKE == HS_NONE);
   c_irq: cover property (O_IRQ);
endmodule
bind uoeb_top uoeb_chk i_chk (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_WR(I_WR), .I_RD(I_RD),
   .I_OUT_TOKEN(I_OUT_TOKEN), .I_PKT_DONE(I_PKT_DONE), .O_ACCEPT(O_ACCEPT), .O_IRQ(O_IRQ), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_HANDSHAKE(O_HANDSHAKE), .O_Y_BASE_ADDR(O_Y_BASE_ADDR));
`default_nettype wire

// ### dv/uoeb_host.sv
// Purpose: host side of out transactions
// Assumes: a token lasts two cycles, data only if the device takes it
// Notes: the length lines toggle outside done so stale values never pass
`timescale 1ns/1ns
`default_nettype none
module uoeb_host
   import uoeb_pkg::*;
(
   input  wire logic             i_clk,    // system clock
   input  wire logic             i_go,     // start one transaction
   input  wire logic [CNT_W-1:0] i_bytes,  // packet length
   input  wire logic             i_accept, // device takes data
   output logic                  o_token,  // out token
   output logic                  o_done,   // packet ended well
   output logic      [CNT_W-1:0] o_bytes   // length beside done
);
   logic ph_q;
   initial begin
      {o_token, o_done, ph_q, o_bytes} = '0;
   end
   always @(posedge i_clk) begin
      o_bytes <= ~o_bytes;
      if (i_go) begin
         o_token <= 1'b1;
         ph_q    <= 1'b0;
      end else if (o_token && !ph_q) begin
         ph_q   <= 1'b1;
         o_done <= i_accept;
         if (i_accept) o_bytes <= i_bytes;
      end else begin
         o_token <= 1'b0;
         o_done  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: self-checking bench for uoeb_top
// Assumes: fixed seed, host model on the token side
// Notes: expectations come from literals and the xc bench function
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import uoeb_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, go = 0, tok, done, acc, irq;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = '0, rdata, b;
   logic [CNT_W-1:0] nb = '0, pb, n;
   logic [1:0] hs;
   logic [MEM_ADDR_W-1:0] yb;
   int err_total = 0, num_checks = 0, seed = 19147, cyc = 0;
   uoeb_top i_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
      .O_RDATA(rdata), .I_OUT_TOKEN(tok), .I_PKT_DONE(done), .I_PKT_BYTES(pb), .O_HANDSHAKE(hs),
      .O_ACCEPT(acc), .O_Y_BASE_ADDR(yb), .O_IRQ(irq));
   uoeb_host i_host (.i_clk(clk), .i_go(go), .i_bytes(nb), .i_accept(acc), .o_token(tok), .o_done(done),
      .o_bytes(pb));
   initial forever #4 clk = ~clk;
   function automatic logic [7:0] xc(logic [6:0] v, int s);
      return {1'b1, 7'(v / (s + 1))};
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic wrr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1;
      chk(rdata === e, "read data");
   endtask
   task automatic pkt(input logic [6:0] v, input logic [1:0] h);
      @(posedge clk) {go, nb} <= {1'b1, v};
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
      #1;
      chk(hs === h, "handshake");
      chk(acc === (h != HS_NAK), "accept");
      repeat (2) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         complete_run;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int a = 0; a < 6; a++) rdc(3'(a), 8'h00);
      repeat (4) begin
         b = 8'($random(seed));
         wrr(OFS_YBASE, b);
         chk(yb === {b, 3'b000}, "y base");
         rdc(OFS_YBASE, b);
      end
      wrr(3'h5, 8'hff);
      rdc(3'h5, 8'h00);
      $display("test registers done");
      wrr(OFS_IRQ_MASK, 8'h03);
      n = 7'($random(seed));
      pkt(n, HS_ACK);
      rdc(OFS_XCNT, {1'b1, n});
      chk(irq === 1'b1, "irq on packet");
      pkt(~n, HS_NAK);
      rdc(OFS_XCNT, {1'b1, n});
      wrr(OFS_IRQ_STAT, 8'h01);
      rdc(OFS_IRQ_STAT, 8'h02);
      wrr(OFS_IRQ_MASK, 8'h01);
      chk(irq === 1'b0, "irq masked");
      wrr(OFS_XCNT, 8'h00);
      pkt(n, HS_ACK);
      $display("test bulk done");
      for (int s = 0; s < 8; s++) begin
         wrr(OFS_CFG, 8'h80 | 8'(s));
         n = 7'($random(seed));
         pkt(n, HS_NONE);
         rdc(OFS_XCNT, xc(n, s));
         // odd rounds clear valid after their read, so round 0 and the odd rounds take a packet over a set valid bit
         if (s % 2 == 1) wrr(OFS_XCNT, 8'h00);
      end
      wrr(OFS_IRQ_MASK, 8'h00);
      chk(irq === 1'b0, "irq off");
      @(posedge clk) nrst <= 1'b0;
      @(posedge clk) nrst <= 1'b1;
      rdc(OFS_XCNT, 8'h00);
      chk(yb === 11'h000, "y base after reset");
      $display("test iso done");
      complete_run;
   end
endmodule
`default_nettype wire
